// ==== design/mac_stat_pkg.sv ====
// Purpose: shared constants for the frame statistics counter block
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes:   counter offsets are word aligned, one counter per word
package mac_stat_pkg;
  // ****************************************
  // counter layout
  // ****************************************
  localparam int NUM_CNT          = 16;
  localparam int CNT_W            = 32;
  localparam int ADDR_W           = 7;
  localparam int LEN_W            = 16;
  localparam int THR_W            = 8;
  localparam int IDX_TOO_LONG     = 0;
  localparam int IDX_LONG_ERR     = 1;
  localparam int IDX_TOO_SHORT    = 2;
  localparam int IDX_SHORT_ERR    = 3;
  localparam int IDX_ADDR_DISCARD = 4;
  localparam int IDX_QOS_DROP     = 5;
  localparam int IDX_GOOD_BYTE    = 6;
  localparam int IDX_START_OVR    = 7;
  localparam int IDX_MIDDLE_OVR   = 8;
  localparam int IDX_BUFFER_OVR   = 9;
  localparam int IDX_TX_GOOD      = 10;
  localparam int IDX_TX_BCAST     = 11;
  localparam int IDX_TX_MCAST     = 12;
  localparam int IDX_TX_PAUSE     = 13;
  localparam int IDX_TX_WAIT      = 14;
  localparam int IDX_FRAME64      = 15;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CNT_BASE  = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 7'h40;
  localparam logic [ADDR_W-1:0] OFS_LEN_LIMIT = 7'h44;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 7'h48;

  // ****************************************
  // control and status fields
  // ****************************************
  localparam int CTL_MII_ENABLE   = 0;
  localparam int CTL_STAT_INT_EN  = 1;
  localparam int CTL_FULL_DUPLEX  = 2;
  localparam int CTL_QOS_ENABLE   = 3;
  localparam int STS_PENDING      = 0;
  localparam int STS_CLEARING     = 1;

  // ****************************************
  // reset values and frame figures
  // ****************************************
  localparam logic [LEN_W-1:0] LEN_LIMIT_RESET = 16'h05EE;
  localparam logic [LEN_W-1:0] MIN_FRAME_LEN   = 16'h0040;
  localparam logic [5:0]       CLEAR_CYCLES    = 6'h26;
  localparam logic [47:0]      BCAST_ADDR      = 48'hFFFFFFFFFFFF;
  localparam int               MCAST_BIT       = 40;
  localparam logic [CNT_W-1:0] HALF_SCALE      = 32'h80000000;
endpackage

// ==== design/mac_frame_statistics_counters.sv ====
// Purpose: classify finished rx/tx frames and keep 32-bit statistics counters
// Assumes: frame outcome inputs are one-cycle pulses with qualifiers valid alongside
// Notes:   counters are reached over Avalon-MM with waitrequest
//
// Function
// [RULE1] count accepted error-free rx frames longer than the length limit
// [RULE2] count accepted errored rx frames longer than the length limit
// [RULE3] count accepted error-free rx data frames shorter than 64 bytes
// [RULE4] count errored short rx data frames, any address, not flow collisions
// [RULE5] count error-free rx data frames discarded by address filtering
// [RULE6] count good rx frames dropped by qos when threshold >= free buffers
// [RULE7] add byte length of every good rx frame to the octet counter
// [RULE8] count accepted rx frames lost at start for fifo or buffer shortage
// [RULE9] count accepted rx frames lost mid-frame after a clean start
// [RULE10] count accepted rx frames lost because head descriptor was zero
// [RULE11] overrun counts are independent of every other discard class
// [RULE12] count tx frames without late/excess collision, carrier loss, underrun
// [RULE13] count good tx frames sent to the all-ones broadcast address
// [RULE14] count good tx frames sent to other multicast addresses
// [RULE15] count only hardware generated pause frames, never software ones
// [RULE16] generate pause frames only in full duplex
// [RULE17] hardware pause frames also count as multicast and 64-byte frames
// [RULE18] count tx frames that deferred then sent with no collision or fault
// [RULE19] writes subtract saturating at zero with mii enable, else load
// [RULE20] when enabled, flag pending while any counter is at half scale or more
// [RULE21] counters are 32 bits and wrap from all ones to zero
// [RULE22] all counters clear a fixed 38 clocks after reset rises
// [RULE23] classify once when the outcome is final, add one or byte count
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module mac_frame_statistics_counters (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                srst_i,
  // avalon-mm slave
  input  wire logic [mac_stat_pkg::ADDR_W-1:0]     address_i,
  input  wire logic                                read_i,
  input  wire logic                                write_i,
  input  wire logic [3:0]                          byteenable_i,
  input  wire logic [mac_stat_pkg::CNT_W-1:0]      writedata_i,
  output logic      [mac_stat_pkg::CNT_W-1:0]      readdata_o,
  output logic                                     waitrequest_o,
  // receive outcome
  input  wire logic                                rx_done_i,
  input  wire logic [mac_stat_pkg::LEN_W-1:0]      rx_len_i,
  input  wire logic                                rx_addr_match_i,
  input  wire logic                                rx_control_frame_i,
  input  wire logic                                rx_crc_err_i,
  input  wire logic                                rx_align_err_i,
  input  wire logic                                rx_code_err_i,
  input  wire logic                                rx_flow_collision_i,
  input  wire logic                                rx_start_overrun_i,
  input  wire logic                                rx_middle_overrun_i,
  input  wire logic                                rx_buffer_overrun_i,
  input  wire logic [mac_stat_pkg::THR_W-1:0]      rx_channel_flow_threshold_i,
  input  wire logic [mac_stat_pkg::THR_W-1:0]      rx_channel_free_buffers_i,
  // transmit outcome
  input  wire logic                                tx_done_i,
  input  wire logic [mac_stat_pkg::LEN_W-1:0]      tx_len_i,
  input  wire logic [47:0]                         tx_dest_addr_i,
  input  wire logic                                tx_late_coll_i,
  input  wire logic                                tx_excess_coll_i,
  input  wire logic                                tx_carrier_loss_i,
  input  wire logic                                tx_underrun_i,
  input  wire logic [4:0]                          tx_coll_count_i,
  input  wire logic                                tx_deferred_i,
  input  wire logic                                tx_hw_pause_i,
  // status toward the mac
  output logic                                     tx_pause_allowed_o,
  output logic                                     statistics_interrupt_pending_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [mac_stat_pkg::NUM_CNT-1:0][mac_stat_pkg::CNT_W-1:0] cnt;
    logic                                 mii_enable;
    logic                                 stat_int_en;
    logic                                 full_duplex;
    logic                                 rx_qos_enable;
    logic [mac_stat_pkg::LEN_W-1:0]       rx_length_limit;
    logic                                 pending;
    logic [5:0]                           clr_cnt;
    logic                                 rst_seen;
    logic                                 waitreq;
    logic [mac_stat_pkg::CNT_W-1:0]       rdata;
  } state_t;

  state_t state;
  state_t next_state;

  // ****************************************
  // frame classification
  // ****************************************
  logic                                                      rx_err;
  logic                                                      rx_over;
  logic                                                      rx_short;
  logic                                                      rx_good;
  logic                                                      tx_ok;
  logic                                                      pause_ev;
  logic                                                      clearing;
  logic                                                      commit;
  logic [mac_stat_pkg::NUM_CNT-1:0][mac_stat_pkg::CNT_W-1:0] amt;

  assign rx_err   = rx_crc_err_i | rx_align_err_i | rx_code_err_i;
  assign rx_over  = rx_len_i > state.rx_length_limit;
  assign rx_short = rx_len_i < mac_stat_pkg::MIN_FRAME_LEN;
  assign rx_good  = rx_done_i & rx_addr_match_i & !rx_short & !rx_over & !rx_err;
  assign tx_ok    = tx_done_i & !tx_late_coll_i & !tx_excess_coll_i
                  & !tx_carrier_loss_i & !tx_underrun_i; // [RULE12]
  // pause only originates from the mac in full duplex, software ones excluded
  assign pause_ev = tx_done_i & tx_hw_pause_i & state.full_duplex; // [RULE15] [RULE16]
  assign clearing = state.clr_cnt != 6'h00;
  assign commit   = write_i & !state.waitreq;

  always_comb begin
    amt = '0;
    // every term is gated by a done pulse, so a frame is judged once [RULE23]
    amt[mac_stat_pkg::IDX_TOO_LONG] = {31'h0, rx_done_i & rx_addr_match_i
                                       & rx_over & !rx_err}; // [RULE1]
    amt[mac_stat_pkg::IDX_LONG_ERR] = {31'h0, rx_done_i & rx_addr_match_i
                                       & rx_over & rx_err}; // [RULE2]
    amt[mac_stat_pkg::IDX_TOO_SHORT] = {31'h0, rx_done_i & rx_addr_match_i
                                        & !rx_control_frame_i & rx_short & !rx_err}; // [RULE3]
    amt[mac_stat_pkg::IDX_SHORT_ERR] = {31'h0, rx_done_i & !rx_control_frame_i & rx_short
                                        & rx_err & !rx_flow_collision_i}; // [RULE4]
    amt[mac_stat_pkg::IDX_ADDR_DISCARD] = {31'h0, rx_done_i & !rx_addr_match_i
                                           & !rx_control_frame_i & !rx_err}; // [RULE5]
    amt[mac_stat_pkg::IDX_QOS_DROP] = {31'h0, rx_good & state.rx_qos_enable
                                       & (rx_channel_flow_threshold_i
                                          >= rx_channel_free_buffers_i)}; // [RULE6]
    amt[mac_stat_pkg::IDX_GOOD_BYTE] = rx_good ? {16'h0000, rx_len_i} : 32'h00000000; // [RULE7]
    // overruns look at nothing but acceptance and the overrun cause [RULE11]
    amt[mac_stat_pkg::IDX_START_OVR] = {31'h0, rx_done_i & rx_addr_match_i
                                        & rx_start_overrun_i}; // [RULE8]
    amt[mac_stat_pkg::IDX_MIDDLE_OVR] = {31'h0, rx_done_i & rx_addr_match_i
                                         & rx_middle_overrun_i & !rx_start_overrun_i}; // [RULE9]
    amt[mac_stat_pkg::IDX_BUFFER_OVR] = {31'h0, rx_done_i & rx_addr_match_i
                                         & rx_buffer_overrun_i}; // [RULE10]
    amt[mac_stat_pkg::IDX_TX_GOOD] = {31'h0, tx_ok}; // [RULE12]
    amt[mac_stat_pkg::IDX_TX_BCAST] = {31'h0, tx_ok & !pause_ev
                                       & (tx_dest_addr_i == mac_stat_pkg::BCAST_ADDR)}; // [RULE13]
    amt[mac_stat_pkg::IDX_TX_MCAST] = {31'h0, pause_ev | (tx_ok
                                       & tx_dest_addr_i[mac_stat_pkg::MCAST_BIT]
                                       & (tx_dest_addr_i != mac_stat_pkg::BCAST_ADDR))}; // [RULE14] [RULE17]
    amt[mac_stat_pkg::IDX_TX_PAUSE] = {31'h0, pause_ev}; // [RULE15]
    amt[mac_stat_pkg::IDX_TX_WAIT] = {31'h0, tx_done_i & tx_deferred_i
                                      & (tx_coll_count_i == 5'h00) & !tx_late_coll_i
                                      & !tx_excess_coll_i & !tx_carrier_loss_i
                                      & !tx_underrun_i}; // [RULE18]
    // rx and tx may both finish a 64-byte frame in one cycle
    amt[mac_stat_pkg::IDX_FRAME64] = {30'h0,
      ({1'b0, rx_done_i & rx_addr_match_i & (rx_len_i == mac_stat_pkg::MIN_FRAME_LEN)}
       + {1'b0, pause_ev | (tx_ok & (tx_len_i == mac_stat_pkg::MIN_FRAME_LEN))})}; // [RULE17]
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [mac_stat_pkg::CNT_W-1:0] base;
    logic                           hit;
    logic                           any_half;
    base       = '0;
    hit        = 1'b0;
    any_half   = 1'b0;
    next_state = state;

    // bus handshake: one wait cycle, then the access completes
    next_state.waitreq = 1'b1;
    if ((read_i | write_i) && state.waitreq && !clearing && !srst_i) begin
      next_state.waitreq = 1'b0;
      next_state.rdata   = 32'h00000000;
      if (address_i < mac_stat_pkg::OFS_CONTROL) begin
        next_state.rdata = state.cnt[address_i[5:2]];
      end else if (address_i == mac_stat_pkg::OFS_CONTROL) begin
        next_state.rdata[mac_stat_pkg::CTL_MII_ENABLE]  = state.mii_enable;
        next_state.rdata[mac_stat_pkg::CTL_STAT_INT_EN] = state.stat_int_en;
        next_state.rdata[mac_stat_pkg::CTL_FULL_DUPLEX] = state.full_duplex;
        next_state.rdata[mac_stat_pkg::CTL_QOS_ENABLE]  = state.rx_qos_enable;
      end else if (address_i == mac_stat_pkg::OFS_LEN_LIMIT) begin
        next_state.rdata = {16'h0000, state.rx_length_limit};
      end else if (address_i == mac_stat_pkg::OFS_STATUS) begin
        next_state.rdata[mac_stat_pkg::STS_PENDING]  = state.pending;
        next_state.rdata[mac_stat_pkg::STS_CLEARING] = clearing;
      end
    end

    if (commit && byteenable_i == 4'hF) begin
      if (address_i == mac_stat_pkg::OFS_CONTROL) begin
        next_state.mii_enable    = writedata_i[mac_stat_pkg::CTL_MII_ENABLE];
        next_state.stat_int_en   = writedata_i[mac_stat_pkg::CTL_STAT_INT_EN];
        next_state.full_duplex   = writedata_i[mac_stat_pkg::CTL_FULL_DUPLEX];
        next_state.rx_qos_enable = writedata_i[mac_stat_pkg::CTL_QOS_ENABLE];
      end else if (address_i == mac_stat_pkg::OFS_LEN_LIMIT) begin
        next_state.rx_length_limit = writedata_i[mac_stat_pkg::LEN_W-1:0];
      end
    end

    // write result first, event added on top so a same-cycle event is kept
    for (int i = 0; i < mac_stat_pkg::NUM_CNT; i++) begin
      hit  = commit && (byteenable_i == 4'hF) && (address_i < mac_stat_pkg::OFS_CONTROL)
           && (address_i[5:2] == 4'(i)) && (address_i[1:0] == 2'b00);
      base = state.cnt[i];
      if (hit) begin
        if (state.mii_enable) begin
          base = (writedata_i > state.cnt[i]) ? 32'h00000000
                                              : state.cnt[i] - writedata_i; // [RULE19]
        end else begin
          base = writedata_i; // [RULE19]
        end
      end
      next_state.cnt[i] = base + amt[i]; // [RULE21]
      any_half = any_half | (state.cnt[i] >= mac_stat_pkg::HALF_SCALE);
    end

    next_state.pending = state.stat_int_en & any_half & !clearing; // [RULE20]

    // delayed clear, timed from the first cycle reset is seen high
    if (clearing) begin
      next_state.clr_cnt = state.clr_cnt - 6'h01;
    end
    if (state.clr_cnt == 6'h01) begin
      next_state.cnt = '0; // [RULE22]
    end

    if (srst_i) begin
      next_state.rst_seen        = 1'b1;
      next_state.mii_enable      = 1'b0;
      next_state.stat_int_en     = 1'b0;
      next_state.full_duplex     = 1'b0;
      next_state.rx_qos_enable   = 1'b0;
      next_state.rx_length_limit = mac_stat_pkg::LEN_LIMIT_RESET;
      next_state.pending         = 1'b0;
      next_state.waitreq         = 1'b1;
      next_state.rdata           = 32'h00000000;
      // else branch, so an unknown flag at power-up still arms the clear
      if (state.rst_seen) begin
        next_state.rst_seen = 1'b1;
      end else begin
        next_state.clr_cnt = mac_stat_pkg::CLEAR_CYCLES; // [RULE22]
      end
    end else begin
      next_state.rst_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  assign readdata_o                     = state.rdata;
  assign waitrequest_o                  = state.waitreq;
  assign tx_pause_allowed_o             = state.full_duplex; // [RULE16]
  assign statistics_interrupt_pending_o = state.pending;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic quiet;
  assign quiet = !commit && !clearing;

  sequence rx_long_clean_s;
    rx_done_i && rx_addr_match_i && rx_over && !rx_err && quiet;
  endsequence

  sequence tx_pause_s;
    tx_done_i && tx_hw_pause_i && state.full_duplex && quiet;
  endsequence

  too_long_count_a: assert property (rx_long_clean_s |=> // [RULE1]
    state.cnt[mac_stat_pkg::IDX_TOO_LONG] ==
    $past(state.cnt[mac_stat_pkg::IDX_TOO_LONG]) + 32'h1)
    else $error("too long counter missed a frame");

  short_err_flow_a: assert property (rx_done_i && rx_flow_collision_i && quiet |=> // [RULE4]
    $stable(state.cnt[mac_stat_pkg::IDX_SHORT_ERR]))
    else $error("flow collision fragment was counted");

  octet_add_a: assert property (rx_good && quiet |=> // [RULE7]
    state.cnt[mac_stat_pkg::IDX_GOOD_BYTE] ==
    $past(state.cnt[mac_stat_pkg::IDX_GOOD_BYTE]) + {16'h0000, $past(rx_len_i)})
    else $error("octet counter did not add frame length");

  middle_after_start_a: assert property ( // [RULE9]
    rx_done_i && rx_start_overrun_i && rx_middle_overrun_i && quiet |=>
    $stable(state.cnt[mac_stat_pkg::IDX_MIDDLE_OVR]))
    else $error("middle overrun counted after start overrun");

  pause_counts_a: assert property (tx_pause_s |=> // [RULE17]
    state.cnt[mac_stat_pkg::IDX_TX_MCAST] ==
    $past(state.cnt[mac_stat_pkg::IDX_TX_MCAST]) + 32'h1 &&
    state.cnt[mac_stat_pkg::IDX_TX_PAUSE] ==
    $past(state.cnt[mac_stat_pkg::IDX_TX_PAUSE]) + 32'h1)
    else $error("pause frame not counted as pause and multicast");

  sw_pause_ignored_a: assert property (tx_done_i && !tx_hw_pause_i && quiet |=> // [RULE15]
    $stable(state.cnt[mac_stat_pkg::IDX_TX_PAUSE]))
    else $error("software pause frame was counted");

  sub_saturate_a: assert property ( // [RULE19]
    commit && state.mii_enable && byteenable_i == 4'hF && address_i == 7'h0C &&
    writedata_i > state.cnt[mac_stat_pkg::IDX_SHORT_ERR] &&
    amt[mac_stat_pkg::IDX_SHORT_ERR] == 32'h0 && !clearing |=>
    state.cnt[mac_stat_pkg::IDX_SHORT_ERR] == 32'h00000000)
    else $error("subtracting write did not saturate at zero");

  pending_level_a: assert property ( // [RULE20]
    state.stat_int_en && !clearing && state.cnt[mac_stat_pkg::IDX_TOO_SHORT][31] |=>
    statistics_interrupt_pending_o)
    else $error("pending not raised at half scale");

  counter_wrap_a: assert property ( // [RULE21]
    state.cnt[mac_stat_pkg::IDX_TOO_LONG] == 32'hFFFFFFFF && rx_done_i && rx_addr_match_i
    && rx_over && !rx_err && quiet |=>
    state.cnt[mac_stat_pkg::IDX_TOO_LONG] == 32'h00000000)
    else $error("counter did not wrap to zero");

  clear_done_a: assert property (state.clr_cnt == 6'h01 |=> state.cnt == '0) // [RULE22]
    else $error("counters not cleared at end of reset delay");

  bus_answer_a: assert property ( // local design decision: one wait cycle, then the access completes
    (read_i || write_i) && waitrequest_o && !clearing |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus access not answered after one wait cycle");
endmodule // mac_frame_statistics_counters

// ==== test/mac_outcome_model.sv ====
// Purpose: behavioural source of frame outcome pulses from the mac datapath
// Assumes: one pulse per frame, qualifiers meaningful only with the pulse
// Notes:   rx qualifiers and tx dest and bits are inverted between frames so stale values never look valid
`timescale 1ns/1ps
module mac_outcome_model (
  // clock and duplex state
  input  wire logic        clk_i,
  input  wire logic        tx_pause_allowed_i,
  // rx outcome, bits {bov,mov,sov,fc,code,align,crc,ctrl,match}
  output logic             rx_done_o,
  output logic [15:0]      rx_len_o,
  output logic [8:0]       rx_bits_o,
  output logic [15:0]      rx_thr_free_o,
  // tx outcome, bits {hwp,def,und,car,exc,late}
  output logic             tx_done_o,
  output logic [15:0]      tx_len_o,
  output logic [47:0]      tx_dest_o,
  output logic [5:0]       tx_bits_o,
  output logic [4:0]       tx_coll_o
);
  initial begin
    rx_done_o = 1'b0;
    tx_done_o = 1'b0;
  end
  task automatic rx(input logic [15:0] l, input logic [8:0] b, input logic [15:0] t);
    @(posedge clk_i);
    rx_done_o <= 1'b1;
    rx_len_o <= l;
    rx_bits_o <= b;
    rx_thr_free_o <= t;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    rx_len_o <= ~l;
    rx_bits_o <= ~b;
    rx_thr_free_o <= ~t;
  endtask
  task automatic tx(input logic [15:0] l, input logic [47:0] d, input logic [5:0] b,
                    input logic [4:0] n);
    @(posedge clk_i);
    tx_done_o <= 1'b1;
    tx_len_o <= l;
    tx_dest_o <= d;
    tx_bits_o <= {b[5] & tx_pause_allowed_i, b[4:0]};
    tx_coll_o <= n;
    @(posedge clk_i);
    tx_done_o <= 1'b0;
    tx_dest_o <= ~d;
    tx_bits_o <= ~b;
  endtask
endmodule // mac_outcome_model

// ==== test/test_mac_frame_statistics_counters.sv ====
// Purpose: self-checking bench for the frame statistics counters
// Assumes: counters read back over avalon-mm after each batch of frames
// Notes:   expected counts are kept in exp_cnt, indexed like the counter map
`timescale 1ns/1ps
module test_mac_frame_statistics_counters;
  logic clk, srst, rd_req, wr_req, waitreq, pend, pause_ok, rx_done, tx_done;
  logic [6:0] address;
  logic [31:0] wdata, rdata, q;
  logic [15:0] rx_len, rx_tf, tx_len, len_limit;
  logic [8:0] rx_b;
  logic [5:0] tx_b;
  logic [4:0] tx_n;
  logic [47:0] tx_d;
  logic [31:0] exp_cnt [16];
  logic qos;
  int miscompares, checks_done;
  // ****************************************
  // design and partner
  // ****************************************
  mac_frame_statistics_counters u_mac_frame_statistics_counters (
    .clk_i(clk), .srst_i(srst), .address_i(address), .read_i(rd_req), .write_i(wr_req),
    .byteenable_i(4'hF), .writedata_i(wdata), .readdata_o(rdata), .waitrequest_o(waitreq),
    .rx_done_i(rx_done), .rx_len_i(rx_len), .rx_addr_match_i(rx_b[0]),
    .rx_control_frame_i(rx_b[1]), .rx_crc_err_i(rx_b[2]), .rx_align_err_i(rx_b[3]),
    .rx_code_err_i(rx_b[4]), .rx_flow_collision_i(rx_b[5]), .rx_start_overrun_i(rx_b[6]),
    .rx_middle_overrun_i(rx_b[7]), .rx_buffer_overrun_i(rx_b[8]),
    .rx_channel_flow_threshold_i(rx_tf[15:8]), .rx_channel_free_buffers_i(rx_tf[7:0]),
    .tx_done_i(tx_done), .tx_len_i(tx_len), .tx_dest_addr_i(tx_d), .tx_late_coll_i(tx_b[0]),
    .tx_excess_coll_i(tx_b[1]), .tx_carrier_loss_i(tx_b[2]), .tx_underrun_i(tx_b[3]),
    .tx_coll_count_i(tx_n), .tx_deferred_i(tx_b[4]), .tx_hw_pause_i(tx_b[5]),
    .tx_pause_allowed_o(pause_ok), .statistics_interrupt_pending_o(pend));
  mac_outcome_model u_mac_outcome_model (
    .clk_i(clk), .tx_pause_allowed_i(pause_ok), .rx_done_o(rx_done), .rx_len_o(rx_len),
    .rx_bits_o(rx_b), .rx_thr_free_o(rx_tf), .tx_done_o(tx_done), .tx_len_o(tx_len),
    .tx_dest_o(tx_d), .tx_bits_o(tx_b), .tx_coll_o(tx_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd_req <= !w;
    wr_req <= w;
    address <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 300);
    if (n >= 300) miscompares++;
    q = rdata;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
  endtask
  task automatic check_all;
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 7'(4 * i), 32'h0);
      check($sformatf("counter %0d", i), q, exp_cnt[i]);
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
    len_limit = 16'h05EE;
    qos = 1'b0;
  endtask
  task automatic rxf(input logic [15:0] l, input logic [8:0] b, input logic [15:0] t);
    logic m, c, e, ok;
    m = b[0];
    c = b[1];
    e = |b[4:2];
    ok = m && !e && l >= 16'h0040 && l <= len_limit;
    if (m && l > len_limit) exp_cnt[e ? 1 : 0]++;
    if (m && !c && !e && l < 16'h0040) exp_cnt[2]++;
    if (!c && e && !b[5] && l < 16'h0040) exp_cnt[3]++;
    if (!m && !c && !e) exp_cnt[4]++;
    if (ok && qos && t[15:8] >= t[7:0]) exp_cnt[5]++;
    if (ok) exp_cnt[6] += 32'(l);
    if (m && b[6]) exp_cnt[7]++;
    if (m && b[7] && !b[6]) exp_cnt[8]++;
    if (m && b[8]) exp_cnt[9]++;
    if (m && l == 16'h0040) exp_cnt[15]++;
    u_mac_outcome_model.rx(l, b, t);
  endtask
  task automatic txf(input logic [15:0] l, input logic [47:0] d, input logic [5:0] b,
                     input logic [4:0] n);
    logic g;
    g = !(|b[3:0]);
    if (g) exp_cnt[10]++;
    if (g && d == 48'hFFFFFFFFFFFF && !b[5]) exp_cnt[11]++;
    if ((g && d[40] && d != 48'hFFFFFFFFFFFF) || b[5]) exp_cnt[12]++;
    if (b[5]) exp_cnt[13]++;
    if (g && b[4] && n == 5'h00) exp_cnt[14]++;
    if (g && l == 16'h0040) exp_cnt[15]++;
    u_mac_outcome_model.tx(l, d, b, n);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rx;
    bus(1'b1, 7'h40, 32'h0000000C);
    qos = 1'b1;
    rxf(16'h05EF, 9'h001, 16'h0000);
    rxf(16'h05EF, 9'h005, 16'h0000);
    rxf(16'h05EE, 9'h001, 16'h0000);
    rxf(16'h003F, 9'h001, 16'h0000);
    rxf(16'h003F, 9'h003, 16'h0000);
    rxf(16'h003F, 9'h008, 16'h0000);
    rxf(16'h003F, 9'h030, 16'h0000);
    rxf(16'h0064, 9'h000, 16'h0000);
    rxf(16'h0064, 9'h002, 16'h0000);
    rxf(16'h0040, 9'h001, 16'h0505);
    rxf(16'h0040, 9'h001, 16'h0405);
    rxf(16'h0064, 9'h045, 16'h0000);
    rxf(16'h0064, 9'h081, 16'h0000);
    rxf(16'h0064, 9'h0C1, 16'h0000);
    rxf(16'h05EF, 9'h105, 16'h0000);
    rxf(16'h0028, 9'h040, 16'h0000);
    check_all;
  endtask
  task automatic t_tx;
    check("pause allowed", {31'h0, pause_ok}, 32'h1);
    txf(16'h0064, 48'h020000000001, 6'h00, 5'h00);
    txf(16'h0040, 48'hFFFFFFFFFFFF, 6'h00, 5'h00);
    txf(16'h0064, 48'h010000000002, 6'h00, 5'h00);
    for (int i = 0; i < 4; i++) txf(16'h0040, 48'hFFFFFFFFFFFF, 6'h01 << i, 5'h00);
    txf(16'h0064, 48'h020000000001, 6'h10, 5'h00);
    txf(16'h0064, 48'h020000000001, 6'h10, 5'h01);
    txf(16'h0064, 48'h020000000001, 6'h14, 5'h00);
    txf(16'h0040, 48'h0180C2000001, 6'h00, 5'h00);
    txf(16'h0040, 48'h0180C2000001, 6'h20, 5'h00);
    check_all;
  endtask
  task automatic t_reg;
    bus(1'b1, 7'h00, 32'hFFFFFFFF);
    exp_cnt[0] = 32'hFFFFFFFF;
    rxf(16'h05EF, 9'h001, 16'h0000);
    bus(1'b1, 7'h40, 32'h0000000E);
    bus(1'b1, 7'h08, 32'h80000000);
    exp_cnt[2] = 32'h80000000;
    repeat (3) @(negedge clk);
    check("pending", {31'h0, pend}, 32'h1);
    bus(1'b0, 7'h48, 32'h0);
    check("status", q, 32'h00000001);
    bus(1'b1, 7'h40, 32'h0000000F);
    bus(1'b1, 7'h08, 32'h00000001);
    exp_cnt[2] = 32'h7FFFFFFF;
    repeat (3) @(negedge clk);
    check("pending", {31'h0, pend}, 32'h0);
    bus(1'b1, 7'h0C, 32'hFFFFFFFF);
    exp_cnt[3] = 32'h0;
    bus(1'b1, 7'h18, 32'h00000010);
    exp_cnt[6] -= 32'h10;
    bus(1'b0, 7'h4C, 32'h0);
    check("unmapped", q, 32'h0);
    check_all;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    {srst, rd_req, wr_req, address, wdata} = '0;
    srst = 1'b1;
    do_reset();
    check_all;
    bus(1'b0, 7'h44, 32'h0);
    check("length limit", q, 32'h000005EE);
    t_rx();
    t_tx();
    t_reg();
    do_reset();
    check_all;
    check("pause allowed", {31'h0, pause_ok}, 32'h0);
    end_of_test();
  end
endmodule // test_mac_frame_statistics_counters
